// ---- hdl/pcp_pkg.sv ----
package pcp_pkg;

  // port geometry
  localparam int unsigned PCP_PINS = 16;

  // register indices: avalon word address equals the index
  localparam logic [31:0] PCP_DATA_IDX = 32'hFFFF8392;
  localparam logic [31:0] PCP_DIR_IDX  = 32'hFFFF8394;
  localparam logic [31:0] PCP_FUNC_IDX = 32'hFFFF8396;

  // values after reset
  localparam logic [15:0] PCP_DATA_RST = 16'h0000;
  localparam logic [15:0] PCP_DIR_RST  = 16'h0000;
  localparam logic [15:0] PCP_FUNC_RST = 16'h0000;

  // byte lane positions inside the 32-bit bus word
  localparam int unsigned PCP_LANE_HI = 1;
  localparam int unsigned PCP_LANE_LO = 0;

  // chip operating modes
  localparam logic [1:0] PCP_MODE_EXT0   = 2'h0;
  localparam logic [1:0] PCP_MODE_EXT1   = 2'h1;
  localparam logic [1:0] PCP_MODE_EXTROM = 2'h2;
  localparam logic [1:0] PCP_MODE_SINGLE = 2'h3;

  // answer latency of the bus slave in cycles
  localparam int unsigned PCP_WAIT_CYCLES = 1;

  // bus slave states, one-hot
  typedef enum logic [1:0] {
    PCP_ST_IDLE = 2'b01,
    PCP_ST_ACK  = 2'b10
  } pcp_state_t;

  // configuration handed to the pin multiplexer
  typedef struct packed {
    logic [1:0]  mode;
    logic [15:0] data;
    logic [15:0] dir;
    logic [15:0] func;
    logic [15:0] addr;
  } pcp_cfg_t;

  // result per pin from the multiplexer
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
    logic [15:0] rd;
  } pcp_pin_t;

endpackage

// ---- hdl/pcp_pin_mux.sv ----
`timescale 1ns/1ps
module pcp_pin_mux
  import pcp_pkg::*;
(
  input  wire pcp_cfg_t    cfg,
  input  wire logic [15:0] pin_level,
  output pcp_pin_t         pins
);

  genvar g;

  // one slice per port pin
  generate
    for (g = 0; g < PCP_PINS; g++) begin : g_pin
      logic addr_fn;
      logic gpio;
      // address function owns the pin in rom-less extended modes
      assign addr_fn = (cfg.mode == PCP_MODE_EXT0) ||
                       (cfg.mode == PCP_MODE_EXT1) ||
                       ((cfg.mode == PCP_MODE_EXTROM) &&
                        cfg.func[g]);
      assign gpio    = !addr_fn;
      // drive stored bit only as ordinary output
      assign pins.out[g] = addr_fn ? cfg.addr[g] : cfg.data[g];
      assign pins.oe[g]  = addr_fn | (gpio & cfg.dir[g]);
      // readback follows direction bit, never the function
      assign pins.rd[g]  = cfg.dir[g] ? cfg.data[g] : pin_level[g];
    end
  endgenerate

endmodule // pcp_pin_mux

// ---- hdl/pcp_port_c.sv ----
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
// Contract
// - sixteen bidirectional pins, 15 down to 0
// - rom-less extended modes: pins are address outputs
// - rom mode selectable; single-chip mode general only
// - sixteen-bit data register, bit n is pin n
// - fixed address; byte, halfword, word access
// - ordinary output drives last written bit
// - direction one: read returns stored bit
// - direction zero: read returns pin level
// - write always stores; pin only if output
// - power-on reset clears data register
// - data survives manual, watchdog, standby, sleep
module pcp_port_c
  import pcp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        manual_reset,
  input  wire logic [1:0]  chip_mode,
  input  wire logic [15:0] ext_address,
  input  wire logic [31:0] avs_address,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [15:0] port_c_pin_in,
  output logic      [15:0] port_c_pin_out,
  output logic      [15:0] port_c_pin_oe
);

  pcp_state_t  state_r;
  pcp_state_t  state_nxt;
  logic [15:0] port_c_data_r;
  logic [15:0] port_c_direction_control_r;
  logic [15:0] port_c_function_r;
  logic [1:0]  mode_r;
  logic [31:0] readdata_r;
  logic        waitrequest_r;
  logic [15:0] pin_out_r;
  logic [15:0] pin_oe_r;
  logic        req;
  logic        wr_now;
  logic        hit_data;
  logic        hit_dir;
  logic        hit_func;
  logic [31:0] rd_word;
  pcp_cfg_t    cfg;
  pcp_pin_t    pins;

  // merge the two byte lanes of a write into a 16-bit register
  function automatic logic [15:0] merge_lanes(
    input logic [15:0] old,
    input logic [31:0] wdata,
    input logic [3:0]  be
  );
    logic [15:0] res;
    res = old;
    if (be[PCP_LANE_HI]) begin
      res[15:8] = wdata[15:8];
    end
    if (be[PCP_LANE_LO]) begin
      res[7:0] = wdata[7:0];
    end
    return res;
  endfunction

  // request decode
  assign req      = avs_read | avs_write;
  assign hit_data = (avs_address == PCP_DATA_IDX);
  assign hit_dir  = (avs_address == PCP_DIR_IDX);
  assign hit_func = (avs_address == PCP_FUNC_IDX);
  // a write lands on the edge where waitrequest is seen low
  assign wr_now   = (state_r == PCP_ST_ACK) & avs_write;

  // slave handshake: one wait cycle, then a one-cycle answer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PCP_ST_IDLE: begin
        if (req) begin
          state_nxt = PCP_ST_ACK;
        end
      end
      PCP_ST_ACK: begin
        state_nxt = PCP_ST_IDLE;
      end
      default: begin
        state_nxt = PCP_ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= PCP_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // waitrequest stays high except in the answer cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waitrequest_r <= 1'b1;
    end else begin
      waitrequest_r <= (state_nxt != PCP_ST_ACK);
    end
  end

  // mode level taken each cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_r <= PCP_MODE_EXT0;
    end else begin
      mode_r <= chip_mode;
    end
  end

  // data register: only power-on reset clears it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_c_data_r <= PCP_DATA_RST;
    end else if (wr_now && hit_data) begin
      port_c_data_r <= merge_lanes(port_c_data_r, avs_writedata,
                                   avs_byteenable);
    end
  end

  // direction register, cleared by either reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_c_direction_control_r <= PCP_DIR_RST;
    end else if (manual_reset) begin
      port_c_direction_control_r <= PCP_DIR_RST;
    end else if (wr_now && hit_dir) begin
      port_c_direction_control_r <= merge_lanes(
        port_c_direction_control_r, avs_writedata, avs_byteenable);
    end
  end

  // pin function register, cleared by either reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_c_function_r <= PCP_FUNC_RST;
    end else if (manual_reset) begin
      port_c_function_r <= PCP_FUNC_RST;
    end else if (wr_now && hit_func) begin
      port_c_function_r <= merge_lanes(port_c_function_r,
                                       avs_writedata, avs_byteenable);
    end
  end

  // bundle for the pin multiplexer
  assign cfg.mode = mode_r;
  assign cfg.data = port_c_data_r;
  assign cfg.dir  = port_c_direction_control_r;
  assign cfg.func = port_c_function_r;
  assign cfg.addr = ext_address;

  pcp_pin_mux u_mux (
    .cfg       (cfg),
    .pin_level (port_c_pin_in),
    .pins      (pins)
  );

  // read word; unmapped addresses answer zero
  always_comb begin
    rd_word = 32'h00000000;
    if (hit_data) begin
      rd_word[15:0] = pins.rd;
    end else if (hit_dir) begin
      rd_word[15:0] = port_c_direction_control_r;
    end else if (hit_func) begin
      rd_word[15:0] = port_c_function_r;
    end
  end

  // read data captured as the answer cycle begins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readdata_r <= 32'h00000000;
    end else if ((state_r == PCP_ST_IDLE) && avs_read) begin
      readdata_r <= rd_word;
    end else if (state_r == PCP_ST_ACK) begin
      readdata_r <= 32'h00000000;
    end
  end

  // registered pin drive
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_out_r <= 16'h0000;
      pin_oe_r  <= 16'h0000;
    end else begin
      pin_out_r <= pins.out;
      pin_oe_r  <= pins.oe;
    end
  end

  assign avs_readdata    = readdata_r;
  assign avs_waitrequest = waitrequest_r;
  assign port_c_pin_out  = pin_out_r;
  assign port_c_pin_oe   = pin_oe_r;

endmodule // pcp_port_c

// ---- tb/pcp_port_c_assertions.sv ----
`timescale 1ns/1ps
module pcp_port_c_chk (
  input logic        clk,
  input logic        reset,
  input logic        manual_reset,
  input logic [1:0]  chip_mode,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic [15:0] port_c_pin_out,
  input logic [15:0] port_c_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // bus answer timing, read lanes and pin function
  ack_one_a: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("late ack");
  ack_pulse_a: assert property (!avs_waitrequest |=>
    avs_waitrequest) else $error("long ack");
  ack_idle_a: assert property (!(avs_read || avs_write) |=>
    avs_waitrequest) else $error("stray ack");
  rd_idle_a: assert property (avs_waitrequest |->
    avs_readdata == 32'h0) else $error("stray data");
  rd_upper_a: assert property (!avs_waitrequest |->
    avs_readdata[31:16] == 16'h0) else $error("upper bits");
  addr_pins_a: assert property ((chip_mode <= 2'h1)[*3] |->
    port_c_pin_oe == 16'hFFFF) else $error("address pins");
  pin_hold_a: assert property (((chip_mode == 2'h3) &&
    avs_waitrequest && !manual_reset)[*4] |->
    $stable({port_c_pin_out, port_c_pin_oe})) else $error("pins moved");
  reset_pins_a: assert property (disable iff (1'b0) reset |->
    port_c_pin_oe == 16'h0 && avs_waitrequest) else $error("reset");
endmodule // pcp_port_c_chk

bind pcp_port_c pcp_port_c_chk u_chk (.*);

// ---- tb/pcp_pin_model.sv ----
`timescale 1ns/1ps
// far side: drives every pin the port leaves free
module pcp_pin_model (
  input  logic [15:0] port_c_pin_out,
  input  logic [15:0] port_c_pin_oe,
  input  logic [15:0] ext_drv,
  output logic [15:0] port_c_pin_in
);
  // resolved level on each of the sixteen wires
  assign port_c_pin_in = (port_c_pin_out & port_c_pin_oe)
    | (ext_drv & ~port_c_pin_oe);
endmodule // pcp_pin_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb
  import pcp_pkg::*;
;
  logic        clk = 1'b0, reset = 1'b0, manual_reset = 1'b0;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [1:0]  chip_mode = PCP_MODE_SINGLE;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [15:0] ext_address = 16'h3C96, ext_drv = 16'hA5C3;
  logic [15:0] port_c_pin_in, port_c_pin_out, port_c_pin_oe;
  logic [31:0] avs_address = 32'h0, avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  int          err_count, n_checks;
  pcp_port_c u_dut (.*);
  pcp_pin_model u_pins (.*);
  // clock
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // access held until waitrequest is low; a read compares with d
  task automatic acc(input logic w, input logic [15:0] d,
                     input logic [31:0] a = PCP_DATA_IDX,
                     input logic [3:0] be = 4'h3);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_byteenable <= be;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    if (!w) chk(avs_readdata, {16'h0, d});
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // let the pins settle, then compare enables and drive
  task automatic pins(input logic [31:0] e);
    repeat (3) @(posedge clk);
    chk({port_c_pin_oe, port_c_pin_out}, e);
  endtask
  // main sequence
  initial begin
    // a real rising edge so the async reset branch runs at time zero
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    acc(1'b1, 16'hFFFF, PCP_DIR_IDX);
    acc(1'b0, 16'h0000);
    acc(1'b1, 16'h1234);
    pins(32'hFFFF1234);
    acc(1'b1, 16'hAB00, PCP_DATA_IDX, 4'h2);
    acc(1'b1, 16'h00CD, PCP_DATA_IDX, 4'h1);
    acc(1'b0, 16'hABCD);
    acc(1'b1, 16'h00FF, PCP_DIR_IDX);
    acc(1'b1, 16'h5A5A);
    acc(1'b0, 16'hA55A);
    pins(32'h00FF5A5A);
    manual_reset <= 1'b1;
    @(posedge clk);
    manual_reset <= 1'b0;
    @(posedge clk);
    acc(1'b0, 16'hA5C3);
    acc(1'b1, 16'hFFFF, PCP_DIR_IDX);
    acc(1'b0, 16'h5A5A);
    acc(1'b0, 16'h0000, 32'h10);
    chip_mode <= PCP_MODE_EXT1;
    pins(32'hFFFF3C96);
    acc(1'b1, 16'hFF00, PCP_FUNC_IDX);
    chip_mode <= PCP_MODE_EXTROM;
    pins(32'hFFFF3C5A);
    stop_test;
  end
  // watchdog
  initial begin
    #20000;
    err_count++;
    stop_test;
  end
endmodule // tb
